// >>> dv/capture_compare_unit_bench.sv
`timescale 1ns/1ns
module capture_compare_unit_bench;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        slp = 1'h0;
  logic        awv = 1'h0;
  logic        wv = 1'h0;
  logic        arv = 1'h0;
  logic        seen = 1'h0;
  logic        br = 1'h0;
  logic        rr = 1'h0;
  logic [3:0]  ws = 4'hF;
  logic [7:0]  awa = 8'h00;
  logic [7:0]  ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic        awr, wrd, bv, arr, rv, sosc, irq;
  logic [1:0]  bres, rres, r;
  logic [31:0] rdat, d;
  logic [4:0]  pin, po, poe, sev;
  logic [2:0]  tck;
  logic [3:0]  md [5] = '{4'h8, 4'h9, 4'h2, 4'hA, 4'hB};
  int          need [4] = '{1, 1, 4, 16};
  int          n_errors = 0;
  int          n_checks = 0;
  int          cycles = 0;
  // ---------------------------------------------------------------
  // Clock, hang guard and harness
  // ---------------------------------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      final_report();
    end
  end
  // Trigger lasts one cycle, so look mid-cycle
  always @(negedge clk) if (sev[0]) seen = 1'h1;
  ccu_top ccu_top_inst (
    .REF_CLK(clk), .RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrd), .S_AXI_BRESP(bres), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
    .S_AXI_RRESP(rres), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .UNIT_PIN_I(pin),
    .UNIT_PIN_O(po), .UNIT_PIN_OE(poe), .TIMER_CLOCK_INPUT_PIN(tck), .SOSC_IN(sosc),
    .SLEEP_IN(slp), .SPECIAL_EVENT(sev), .IRQ(irq)
  );
  ccu_far_model ccu_far_model_inst (.clk(clk), .pin(pin), .tck(tck), .sosc(sosc));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Values seen mid-cycle are those the next rising edge samples
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    tb = 1'h0;
    awa <= a;
    wd <= v;
    awv <= 1'h1;
    wv <= 1'h1;
    while (!tb) begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wrd;
      tb = bv && br;
      r = bres;
      @(posedge clk);
      if (ta) awv <= 1'h0;
      if (tw) wv <= 1'h0;
      br <= !tb;
    end
  endtask
  task automatic axr(input logic [7:0] a);
    logic ta, tr;
    tr = 1'h0;
    ara <= a;
    arv <= 1'h1;
    while (!tr) begin
      @(negedge clk);
      ta = arv && arr;
      tr = rv && rr;
      d = rdat;
      r = rres;
      @(posedge clk);
      if (ta) arv <= 1'h0;
      rr <= !tr;
    end
  endtask
  task automatic wo(input logic [7:0] a, input logic [31:0] v);
    axw(a, v);
    chk(r, ccu_pkg::RESP_OKAY);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] v);
    axr(a);
    chk(r, ccu_pkg::RESP_OKAY);
    chk(d, v);
  endtask
  task automatic final_report;
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    // Reset value, missing top bits of unit 4, gaps in select A
    rc(8'h0C, 32'h0000_0000);
    wo(8'h0C, 32'h0000_00FF);
    rc(8'h0C, 32'h0000_003F);
    wo(8'h3C, 32'h0000_00FF);
    rc(8'h3C, 32'h0000_00DB);
    wo(8'h3C, 32'h0000_0000);
    axw(8'hFC, 32'h0000_FFFF);
    chk(r, ccu_pkg::RESP_SLVERR);
    axr(8'hFC);
    chk(d, 32'h0000_0000);
    wo(8'h24, 32'h0000_01A5);
    wo(8'h28, 32'h0000_005A);
    rc(8'h24, 32'h0000_00A5);
    rc(8'h28, 32'h0000_005A);
    ws <= 4'h2;
    wo(8'h64, 32'h0000_ABCD);
    ws <= 4'hF;
    rc(8'h64, 32'h0000_AB00);
    // Every compare action of unit 1, timer 1 at full rate
    wo(8'h50, 32'h0000_0001);
    wo(8'h18, 32'h0000_0030);
    for (int i = 0; i < 5; i++) begin
      wo(8'h68, 32'h0000_00FF);
      wo(8'h5C, 32'h0000_0000);
      wo(8'h00, {28'h000_0000, md[i]});
      repeat (80) @(posedge clk);
      rc(8'h68, 32'h0000_0001);
      chk(poe[0], i < 3);
      if (i < 3) chk(po[0], i != 1);
      chk(seen, i == 4);
      if (i == 0) begin
        chk(irq, 1'h0);
        wo(8'h6C, 32'h0000_0001);
        chk(irq, 1'h1);
      end
    end
    axr(8'h5C);
    chk(d < 32'h0000_0031, 1'h1);
    wo(8'h00, 32'h0000_0000);
    wo(8'h68, 32'h0000_0001);
    chk(irq, 1'h0);
    // Timer 2 on the quarter clock holds in sleep, then resumes
    slp <= 1'h1;
    wo(8'h54, 32'h0000_0003);
    wo(8'h60, 32'h0000_0100);
    repeat (40) @(posedge clk);
    rc(8'h60, 32'h0000_0100);
    slp <= 1'h0;
    repeat (40) @(posedge clk);
    axr(8'h60);
    chk(d > 32'h0000_0100 && d < 32'h0000_0120, 1'h1);
    // Unit 2 captures timer 1 fed from its clock pin while asleep
    slp <= 1'h1;
    wo(8'h50, 32'h0000_0007);
    wo(8'h5C, 32'h0000_1234);
    for (int i = 0; i < 4; i++) begin
      wo(8'h04, 32'h0000_0000);
      wo(8'h04, 32'h0000_0004 + i);
      wo(8'h68, 32'h0000_00FF);
      repeat (need[i] - 1) ccu_far_model_inst.edges(9'h002);
      rc(8'h68, 32'h0000_0000);
      ccu_far_model_inst.edges(9'h002);
      rc(8'h68, 32'h0000_0002);
    end
    rc(8'h20, 32'h0000_0034);
    repeat (2) ccu_far_model_inst.edges(9'h020);
    wo(8'h04, 32'h0000_0005);
    ccu_far_model_inst.edges(9'h002);
    rc(8'h1C, 32'h0000_0012);
    rc(8'h20, 32'h0000_0036);
    wo(8'h50, 32'h0000_0005);
    ccu_far_model_inst.edges(9'h100);
    rc(8'h5C, 32'h0000_1237);
    final_report();
  end
endmodule

// >>> dv/ccu_checker.sv
`timescale 1ns/1ns
module ccu_checker (
  input wire logic       REF_CLK,
  input wire logic       RST,
  input wire logic       S_AXI_AWVALID,
  input wire logic       S_AXI_AWREADY,
  input wire logic       S_AXI_WVALID,
  input wire logic       S_AXI_WREADY,
  input wire logic       S_AXI_BVALID,
  input wire logic       S_AXI_BREADY,
  input wire logic       S_AXI_ARVALID,
  input wire logic       S_AXI_ARREADY,
  input wire logic       S_AXI_RVALID,
  input wire logic       S_AXI_RREADY,
  input wire logic [4:0] UNIT_PIN_O,
  input wire logic [4:0] UNIT_PIN_OE,
  input wire logic [4:0] SPECIAL_EVENT,
  input wire logic       IRQ
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // ---------------------------------------------------------------
  // Port relations
  // ---------------------------------------------------------------
  // Both halves taken: refused next cycle, answer the cycle after
  write_resp_a:
    assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      |=> !S_AXI_AWREADY && !S_AXI_WREADY ##1 S_AXI_BVALID) else $error("no write answer");
  read_resp_a:
    assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
      else $error("no read answer");
  bresp_done_a:
    assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID) else $error("b repeated");
  rresp_done_a:
    assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID) else $error("r repeated");
  sev_pulse_a:
    assert property (|SPECIAL_EVENT |=> (SPECIAL_EVENT & $past(SPECIAL_EVENT)) == 5'h00)
      else $error("trigger longer than one cycle");
  sev_no_pin_a:
    assert property ((SPECIAL_EVENT & UNIT_PIN_OE) == 5'h00) else $error("trigger drives pin");
  // A latch may only rise on a unit that owns its pin
  pin_rise_a:
    assert property (UNIT_PIN_O != $past(UNIT_PIN_O)
      |-> (UNIT_PIN_O & ~$past(UNIT_PIN_O) & ~UNIT_PIN_OE) == 5'h00) else $error("pin rose");
  irq_clear_a:
    assert property ($fell(IRQ) |-> $rose(S_AXI_BVALID)) else $error("irq fell alone");
  cover property (|SPECIAL_EVENT);
  cover property ($rose(IRQ));
  cover property ($rose(UNIT_PIN_OE[0]));
endmodule

bind ccu_top ccu_checker ccu_checker_inst (
  .REF_CLK(REF_CLK), .RST(RST), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .UNIT_PIN_O(UNIT_PIN_O), .UNIT_PIN_OE(UNIT_PIN_OE), .SPECIAL_EVENT(SPECIAL_EVENT), .IRQ(IRQ)
);

// >>> dv/ccu_far_model.sv
`timescale 1ns/1ns
module ccu_far_model (
  input  wire logic       clk,
  output logic      [4:0] pin,
  output logic      [2:0] tck,
  output logic            sosc
);
  // Lines idle low until pulsed
  initial begin
    pin = 5'h00;
    tck = 3'h0;
    sosc = 1'h0;
  end
  // One pulse on the chosen lines, long enough for the synchronisers
  task edges(input logic [8:0] sel);
    repeat (4) @(posedge clk);
    {sosc, tck, pin} <= sel;
    repeat (4) @(posedge clk);
    {sosc, tck, pin} <= 9'h000;
    repeat (4) @(posedge clk);
  endtask
endmodule

// >>> rtl/ccu_top.sv
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ns
module ccu_top (
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic [4:0]  UNIT_PIN_I,
  output logic [4:0]       UNIT_PIN_O,
  output logic [4:0]       UNIT_PIN_OE,
  input  wire logic [2:0]  TIMER_CLOCK_INPUT_PIN,
  input  wire logic        SOSC_IN,
  input  wire logic        SLEEP_IN,
  output logic [4:0]       SPECIAL_EVENT,
  output logic             IRQ
);

  localparam int NU = ccu_pkg::NUM_UNITS;
  localparam int NT = ccu_pkg::NUM_TMRS;

  // ---------------------------------------------------------------
  // Registers and shared nets
  // ---------------------------------------------------------------
  ccu_pkg::ccu_ctrl_s ctrl_reg [NU];
  ccu_pkg::ccu_tctl_s tctl_reg [NT];
  logic [15:0] val_reg      [NU];
  logic [15:0] tcnt_reg     [NT];
  logic [1:0]  unit_tsel    [NU];
  logic [1:0]  unit_tidx    [NU];
  logic [7:0]  tsel_a_reg;
  logic [7:0]  tsel_b_reg;
  logic [2:0]  prio_reg;
  logic [7:0]  status_reg;
  logic [7:0]  mask_reg;
  logic [7:0]  stat_clr;
  logic [NU-1:0] unit_flag_set;
  logic [NU-1:0] unit_sev;
  logic [NT-1:0] tmr_clr_req;
  logic [NT-1:0] tmr_clr_pend_reg;
  logic [NT-1:0] tmr_tick;
  logic [NT-1:0] tmr_ovf;
  logic [1:0]  div4_reg;
  logic        quart_en;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [ccu_pkg::NUM_SYNC-1:0] pin_raw;
  logic [ccu_pkg::NUM_SYNC-1:0] sync0_reg;
  logic [ccu_pkg::NUM_SYNC-1:0] sync1_reg;
  logic [ccu_pkg::NUM_SYNC-1:0] prev_reg;
  logic [ccu_pkg::NUM_SYNC-1:0] rise;
  logic [ccu_pkg::NUM_SYNC-1:0] fall;
  logic        sleep_s;

  assign pin_raw = {SLEEP_IN, SOSC_IN, TIMER_CLOCK_INPUT_PIN, UNIT_PIN_I};

  // Two flops before use, third flop only for edge detection
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sync0_reg <= '0;
      sync1_reg <= '0;
      prev_reg  <= '0;
    end else begin
      sync0_reg <= pin_raw;
      sync1_reg <= sync0_reg;
      prev_reg  <= sync1_reg;
    end
  end

  assign rise    = sync1_reg & ~prev_reg;
  assign fall    = ~sync1_reg & prev_reg;
  assign sleep_s = sync1_reg[9];

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;
  logic        wr_fire;
  logic        rd_fire;
  logic [31:0] rd_next;
  logic        rd_hit;
  logic        wr_hit;

  // Address and data may arrive in either order; each is parked until both are present
  assign S_AXI_AWREADY = !aw_hold_reg && !bvalid_reg;
  assign S_AXI_WREADY  = !w_hold_reg && !bvalid_reg;
  assign S_AXI_ARREADY = !rvalid_reg;
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;
  assign S_AXI_RVALID  = rvalid_reg;
  assign S_AXI_RRESP   = rresp_reg;
  assign S_AXI_RDATA   = rdata_reg;
  assign wr_fire       = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign rd_fire       = S_AXI_ARVALID && !rvalid_reg;

  // Write channel capture and response
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= ccu_pkg::BYTE_RST;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= ccu_pkg::RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= S_AXI_WDATA;
        wstrb_reg  <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? ccu_pkg::RESP_OKAY : ccu_pkg::RESP_SLVERR;
      end else if (bvalid_reg && S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read data is registered on the same edge that takes the address
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= ccu_pkg::RESP_OKAY;
      rdata_reg  <= '0;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_hit ? ccu_pkg::RESP_OKAY : ccu_pkg::RESP_SLVERR;
      rdata_reg  <= rd_next;
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Read mux; narrow registers sit in the low bits, upper bits zero
  always_comb begin
    rd_next = '0;
    rd_hit  = 1'b1;
    case (S_AXI_ARADDR)
      ccu_pkg::TSEL_A_OFS:   rd_next[7:0] = tsel_a_reg;
      ccu_pkg::TSEL_B_OFS:   rd_next[7:0] = tsel_b_reg;
      ccu_pkg::PRIO_OFS:     rd_next[2:0] = prio_reg;
      ccu_pkg::IRQ_EN_OFS:   rd_next[2:0] = mask_reg[4:2];
      ccu_pkg::IRQ_FLAG_OFS: rd_next[2:0] = status_reg[4:2];
      ccu_pkg::STATUS_OFS:   rd_next[7:0] = status_reg;
      ccu_pkg::MASK_OFS:     rd_next[7:0] = mask_reg;
      default:               rd_hit = 1'b0;
    endcase
    for (int u = 0; u < NU; u++) begin
      if (S_AXI_ARADDR == ccu_pkg::CTRL_BASE + 8'(4 * u)) begin
        rd_next[7:0] = ctrl_reg[u];
        rd_hit       = 1'b1;
      end
      if (S_AXI_ARADDR == ccu_pkg::VAL_HI_BASE + 8'(8 * u)) begin
        rd_next[7:0] = val_reg[u][15:8];
        rd_hit       = 1'b1;
      end
      if (S_AXI_ARADDR == ccu_pkg::VAL_LO_BASE + 8'(8 * u)) begin
        rd_next[7:0] = val_reg[u][7:0];
        rd_hit       = 1'b1;
      end
    end
    for (int t = 0; t < NT; t++) begin
      if (S_AXI_ARADDR == ccu_pkg::TCTL_BASE + 8'(4 * t)) begin
        rd_next[7:0] = {5'h0_0, tctl_reg[t].src, tctl_reg[t].on};
        rd_hit       = 1'b1;
      end
      if (S_AXI_ARADDR == ccu_pkg::TCNT_BASE + 8'(4 * t)) begin
        rd_next[15:0] = tcnt_reg[t];
        rd_hit        = 1'b1;
      end
    end
  end

  // Write decode for the error response
  always_comb begin
    wr_hit = (awaddr_reg == ccu_pkg::TSEL_A_OFS) || (awaddr_reg == ccu_pkg::TSEL_B_OFS) ||
             (awaddr_reg == ccu_pkg::PRIO_OFS) || (awaddr_reg == ccu_pkg::IRQ_EN_OFS) ||
             (awaddr_reg == ccu_pkg::IRQ_FLAG_OFS) || (awaddr_reg == ccu_pkg::STATUS_OFS) ||
             (awaddr_reg == ccu_pkg::MASK_OFS);
    for (int u = 0; u < NU; u++) begin
      if ((awaddr_reg == ccu_pkg::CTRL_BASE + 8'(4 * u)) ||
          (awaddr_reg == ccu_pkg::VAL_HI_BASE + 8'(8 * u)) ||
          (awaddr_reg == ccu_pkg::VAL_LO_BASE + 8'(8 * u))) begin
        wr_hit = 1'b1;
      end
    end
    for (int t = 0; t < NT; t++) begin
      if ((awaddr_reg == ccu_pkg::TCTL_BASE + 8'(4 * t)) ||
          (awaddr_reg == ccu_pkg::TCNT_BASE + 8'(4 * t))) begin
        wr_hit = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Shared configuration registers
  // ---------------------------------------------------------------
  // unimplemented select bits
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tsel_a_reg <= ccu_pkg::BYTE_RST;
      tsel_b_reg <= ccu_pkg::BYTE_RST;
      prio_reg   <= '0;
      mask_reg   <= ccu_pkg::BYTE_RST;
    end else if (wr_fire && wstrb_reg[0]) begin
      case (awaddr_reg)
        ccu_pkg::TSEL_A_OFS: tsel_a_reg <= wdata_reg[7:0] & 8'hDB;
        ccu_pkg::TSEL_B_OFS: tsel_b_reg <= wdata_reg[7:0] & 8'h0F;
        ccu_pkg::PRIO_OFS:   prio_reg   <= wdata_reg[2:0];
        ccu_pkg::IRQ_EN_OFS: mask_reg[4:2] <= wdata_reg[2:0];
        ccu_pkg::MASK_OFS:   mask_reg   <= wdata_reg[7:0];
        default:             mask_reg   <= mask_reg;
      endcase
    end
  end

  assign unit_tsel[0] = tsel_a_reg[1:0];
  assign unit_tsel[1] = tsel_a_reg[4:3];
  assign unit_tsel[2] = tsel_a_reg[7:6];
  assign unit_tsel[3] = tsel_b_reg[1:0];
  assign unit_tsel[4] = tsel_b_reg[3:2];

  // Write-one-clear mask from either status alias
  always_comb begin
    stat_clr = '0;
    if (wr_fire && wstrb_reg[0] && awaddr_reg == ccu_pkg::STATUS_OFS) begin
      stat_clr = wdata_reg[7:0];
    end
    if (wr_fire && wstrb_reg[0] && awaddr_reg == ccu_pkg::IRQ_FLAG_OFS) begin
      stat_clr[4:2] = wdata_reg[2:0];
    end
  end

  // Event status: hardware set wins over a same-cycle write-one clear
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      status_reg <= ccu_pkg::BYTE_RST;
    end else begin
      status_reg <= (status_reg & ~stat_clr) | {tmr_ovf, unit_flag_set};
    end
  end

  assign IRQ = |(status_reg & mask_reg);

  // ---------------------------------------------------------------
  // Time-base timers
  // ---------------------------------------------------------------
  // quarter-rate enable from a divider
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      div4_reg <= '0;
    end else begin
      div4_reg <= div4_reg + 2'h1;
    end
  end

  assign quart_en = (div4_reg == ccu_pkg::DIV4_LAST);

  // Clear requests from special event units, grouped per timer
  always_comb begin
    tmr_clr_req = '0;
    for (int u = 0; u < NU; u++) begin
      if (unit_sev[u]) begin
        tmr_clr_req[unit_tidx[u]] = 1'b1;
      end
    end
  end

  genvar t;
  generate
    for (t = 0; t < NT; t++) begin : g_tmr
      logic ext_edge;
      logic cnt_wr;

      // clock choice; internal clocks stall in sleep; external keeps going
      assign ext_edge = (tctl_reg[t].src == ccu_pkg::SRC_SOSC) ? rise[8] : rise[5 + t];
      always_comb begin
        case (tctl_reg[t].src)
          ccu_pkg::SRC_SYS:   tmr_tick[t] = tctl_reg[t].on && !sleep_s;
          ccu_pkg::SRC_QUART: tmr_tick[t] = tctl_reg[t].on && !sleep_s && quart_en;
          default:            tmr_tick[t] = tctl_reg[t].on && ext_edge;
        endcase
      end

      assign cnt_wr = wr_fire && awaddr_reg == ccu_pkg::TCNT_BASE + 8'(4 * t);
      // reset on timer's next edge, overflow flag untouched
      assign tmr_ovf[t] = tmr_tick[t] && !tmr_clr_pend_reg[t] && !tmr_clr_req[t] && !cnt_wr &&
                          tcnt_reg[t] == ccu_pkg::CNT_MAX;

      // count only moves on a tick or a register write, so it resumes where sleep left it
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          tcnt_reg[t]         <= ccu_pkg::WORD_RST;
          tmr_clr_pend_reg[t] <= 1'b0;
          tctl_reg[t]         <= '0;
        end else begin
          if (wr_fire && wstrb_reg[0] && awaddr_reg == ccu_pkg::TCTL_BASE + 8'(4 * t)) begin
            tctl_reg[t] <= {5'h0_0, wdata_reg[2:0]};
          end
          if (cnt_wr) begin
            if (wstrb_reg[0]) tcnt_reg[t][7:0]  <= wdata_reg[7:0];
            if (wstrb_reg[1]) tcnt_reg[t][15:8] <= wdata_reg[15:8];
            tmr_clr_pend_reg[t] <= 1'b0;
          end else if (tmr_tick[t] && (tmr_clr_pend_reg[t] || tmr_clr_req[t])) begin
            // clear on the next tick, never one past the match
            tcnt_reg[t]         <= ccu_pkg::WORD_RST;
            tmr_clr_pend_reg[t] <= 1'b0;
          end else begin
            if (tmr_tick[t]) tcnt_reg[t] <= tcnt_reg[t] + 16'h0001;
            if (tmr_clr_req[t]) tmr_clr_pend_reg[t] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Capture/compare units
  // ---------------------------------------------------------------
  genvar u;
  generate
    for (u = 0; u < NU; u++) begin : g_unit
      logic [3:0]  mode;
      logic [15:0] count;
      logic        is_cap;
      logic        is_cmp;
      logic        cap_evt;
      logic        eq;
      logic        eq_prev_reg;
      logic        match;
      logic [3:0]  pre_reg;
      logic        out_reg;
      logic        sev_reg;
      logic        ctrl_wr;

      assign mode = ctrl_reg[u].unit_mode_field;
      // code 11 falls back to the first timer
      assign unit_tidx[u] = (unit_tsel[u] == 2'h3) ? 2'h0 : unit_tsel[u];
      // time base from the selected timer
      assign count  = tcnt_reg[unit_tidx[u]];
      assign is_cap = (mode[3:2] == 2'b01);
      assign is_cmp = (mode == ccu_pkg::MODE_TOGGLE) || (mode[3:2] == 2'b10);

      // edge choice and prescale; sampling never stops in sleep
      always_comb begin
        case (mode)
          ccu_pkg::MODE_CAP_FALL: cap_evt = fall[u];
          ccu_pkg::MODE_CAP_RISE: cap_evt = rise[u];
          ccu_pkg::MODE_CAP_4:    cap_evt = rise[u] && pre_reg[1:0] == ccu_pkg::PRE4_LAST[1:0];
          ccu_pkg::MODE_CAP_16:   cap_evt = rise[u] && pre_reg == ccu_pkg::PRE16_LAST;
          default:                cap_evt = 1'b0;
        endcase
      end

      // compare every cycle; a held equal count acts once
      assign eq    = is_cmp && (count == val_reg[u]);
      assign match = eq && !eq_prev_reg;
      assign ctrl_wr = wr_fire && wstrb_reg[0] && awaddr_reg == ccu_pkg::CTRL_BASE + 8'(4 * u);

      // flag with the action; capture also flags
      assign unit_flag_set[u] = cap_evt || match;
      assign unit_sev[u]      = match && mode == ccu_pkg::MODE_SEV;
      assign SPECIAL_EVENT[u] = sev_reg;
      assign UNIT_PIN_O[u]    = out_reg;
      // pin only driven by the three pin modes
      assign UNIT_PIN_OE[u]   = (mode == ccu_pkg::MODE_TOGGLE) || (mode == ccu_pkg::MODE_SET) ||
                                (mode == ccu_pkg::MODE_CLR);

      // Control register; prescaler clears outside capture modes
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          ctrl_reg[u] <= '0;
          pre_reg     <= '0;
          eq_prev_reg <= 1'b0;
          sev_reg     <= 1'b0;
        end else begin
          // mode field in low nibble; top bits absent on standard units
          if (ctrl_wr) begin
            ctrl_reg[u] <= (u < ccu_pkg::NUM_ENH) ? wdata_reg[7:0] : {2'b00, wdata_reg[5:0]};
          end
          if (!is_cap) pre_reg <= '0;
          else if (rise[u]) pre_reg <= pre_reg + 4'h1;
          eq_prev_reg <= eq;
          sev_reg     <= unit_sev[u];
        end
      end

      // one action per match; clearing the mode forces the latch low
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          out_reg <= 1'b0;
        end else if (mode == ccu_pkg::MODE_OFF) begin
          out_reg <= 1'b0;
        end else if (match) begin
          case (mode)
            ccu_pkg::MODE_TOGGLE: out_reg <= !out_reg;
            ccu_pkg::MODE_SET:    out_reg <= 1'b1;
            ccu_pkg::MODE_CLR:    out_reg <= 1'b0;
            default:              out_reg <= out_reg;
          endcase
        end
      end

      // byte-wide access; capture overwrites, winning over a write
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          val_reg[u] <= ccu_pkg::WORD_RST;
        end else if (cap_evt) begin
          val_reg[u] <= count;
        end else if (wr_fire && wstrb_reg[0]) begin
          if (awaddr_reg == ccu_pkg::VAL_HI_BASE + 8'(8 * u)) val_reg[u][15:8] <= wdata_reg[7:0];
          if (awaddr_reg == ccu_pkg::VAL_LO_BASE + 8'(8 * u)) val_reg[u][7:0]  <= wdata_reg[7:0];
        end
      end
    end
  endgenerate

endmodule

// >>> shared/ccu_pkg.sv
// Contract
// - Capture time base is a selected 16-bit timer
// - Timer clocks: system, quarter, secondary, pin
// - Internal-clocked timer holds count in sleep
// - After sleep timer resumes from held count
// - Capture works in sleep with external timer clock
// - Compare value against selected timer every cycle
// - Match does one configured action only
// - Low 4-bit mode field selects match action
// - Event flag set with match action
// - Value register: separate high and low bytes
// - Unimplemented bits read as zero
// - Capture copies count, sets flag, overwrites
// - Capture edges: fall, rise, 4th, 16th rise
// - Mode 1010 flags only, pin untouched
// - Mode 1011 flags, clears timer, no overflow
package ccu_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_BASE    = 8'h00;  // Unit n at CTRL_BASE + 4n
  localparam logic [7:0] VAL_HI_BASE  = 8'h14;  // Unit n at VAL_HI_BASE + 8n
  localparam logic [7:0] VAL_LO_BASE  = 8'h18;  // Unit n at VAL_LO_BASE + 8n
  localparam logic [7:0] TSEL_A_OFS   = 8'h3C;
  localparam logic [7:0] TSEL_B_OFS   = 8'h40;
  localparam logic [7:0] PRIO_OFS     = 8'h44;
  localparam logic [7:0] IRQ_EN_OFS   = 8'h48;
  localparam logic [7:0] IRQ_FLAG_OFS = 8'h4C;
  localparam logic [7:0] TCTL_BASE    = 8'h50;  // Timer t at TCTL_BASE + 4t
  localparam logic [7:0] TCNT_BASE    = 8'h5C;  // Timer t at TCNT_BASE + 4t
  localparam logic [7:0] STATUS_OFS   = 8'h68;
  localparam logic [7:0] MASK_OFS     = 8'h6C;

  // ---------------------------------------------------------------
  // Sizes, reset values and field layouts
  // ---------------------------------------------------------------
  localparam int NUM_UNITS  = 5;
  localparam int NUM_TMRS   = 3;
  localparam int NUM_ENH    = 3;               // Units with the top two control bits
  localparam int NUM_SYNC   = 10;              // 5 unit pins, 3 clock pins, sosc, sleep
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic [15:0] WORD_RST  = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic [1:0]  DIV4_LAST = 2'h3;
  localparam logic [3:0]  PRE4_LAST = 4'h3;
  localparam logic [3:0]  PRE16_LAST = 4'hF;
  localparam int STAT_TOVF_POS = 5;            // Timer overflow flags at bits 7:5

  // Mode field codes
  localparam logic [3:0] MODE_OFF     = 4'h0;
  localparam logic [3:0] MODE_TOGGLE  = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4   = 4'h6;
  localparam logic [3:0] MODE_CAP_16  = 4'h7;
  localparam logic [3:0] MODE_SET     = 4'h8;
  localparam logic [3:0] MODE_CLR     = 4'h9;
  localparam logic [3:0] MODE_SWINT   = 4'hA;
  localparam logic [3:0] MODE_SEV     = 4'hB;

  // Timer clock sources
  localparam logic [1:0] SRC_SYS   = 2'h0;
  localparam logic [1:0] SRC_QUART = 2'h1;
  localparam logic [1:0] SRC_SOSC  = 2'h2;
  localparam logic [1:0] SRC_PIN   = 2'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] enhanced_output_config;
    logic [1:0] pwm_duty_low_bits;
    logic [3:0] unit_mode_field;
  } ccu_ctrl_s;

  typedef struct packed {
    logic [4:0] reserved;
    logic [1:0] src;
    logic       on;
  } ccu_tctl_s;

endpackage
